// *** hdl/pwrseq_map.svh ***
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef PWRSEQ_MAP_SVH
`define PWRSEQ_MAP_SVH

// Clock and oscillator rates
`define PWRSEQ_CLK_HZ 20000000
`define PWRSEQ_CLK_PERIOD_NS 50
`define PWRSEQ_OSC_HZ 2000000
`define PWRSEQ_OSC_DIV (`PWRSEQ_CLK_HZ / `PWRSEQ_OSC_HZ)
`define PWRSEQ_LP_DIV 64
`define PWRSEQ_HOLD_PERIODS 256

// Low-power clock settling time after enable, least time rounds up
`define PWRSEQ_TSTAB_NS 10000
`define PWRSEQ_TSTAB_CYC \
  ((`PWRSEQ_TSTAB_NS + `PWRSEQ_CLK_PERIOD_NS - 1) / `PWRSEQ_CLK_PERIOD_NS)

// Pin population: digital pins first, then mixed-signal, then wakeup
`define PWRSEQ_N_DIG 12
`define PWRSEQ_N_MS 2
`define PWRSEQ_N_PIN 15
`define PWRSEQ_FIRST_MS 12
`define PWRSEQ_WAKE_PIN 14
`define PWRSEQ_N_IN 18
`define PWRSEQ_IN_CHIP 15
`define PWRSEQ_IN_SLOW 16
`define PWRSEQ_IN_DROP 17

// Register byte offsets
`define PWRSEQ_CTRL_OFS 8'h00
`define PWRSEQ_STATUS_OFS 8'h04
`define PWRSEQ_PIN_OUT_OFS 8'h08
`define PWRSEQ_PIN_DRIVE_OFS 8'h0c
`define PWRSEQ_PIN_PULL_EN_OFS 8'h10
`define PWRSEQ_PIN_PULL_UP_OFS 8'h14
`define PWRSEQ_ANALOG_OFS 8'h18
`define PWRSEQ_PIN_LEVEL_OFS 8'h1c

// Control fields and software state requests
`define PWRSEQ_CTRL_REQ_LSB 0
`define PWRSEQ_CTRL_PROG_BIT 2
`define PWRSEQ_REQ_MCU 2'h0
`define PWRSEQ_REQ_RADIO 2'h1
`define PWRSEQ_REQ_SLEEP 2'h2

// Status fields
`define PWRSEQ_STAT_SLOW_BIT 3
`define PWRSEQ_STAT_DROP_BIT 4
`define PWRSEQ_STAT_STABLE_BIT 5
`define PWRSEQ_STAT_PROG_BIT 6

// Reset values
`define PWRSEQ_ANALOG_RST 2'h3
`define PWRSEQ_PIN_RST 15'h0000

`endif

// *** hdl/pwrseq_pkg.sv ***
// Types shared by the power state and reset sequencer
package pwrseq_pkg;

  typedef enum logic [2:0] {
    PWRSEQ_OFF,
    PWRSEQ_OSC_WAIT,
    PWRSEQ_HOLD,
    PWRSEQ_MCU_ONLY,
    PWRSEQ_RADIO_ACTIVE,
    PWRSEQ_DEEP_SLEEP
  } pwrseq_state_t;

  // Pad controls of all fifteen pins
  typedef struct packed {
    logic [14:0] out;
    logic [14:0] oe_n;
    logic [14:0] in_en;
    logic [14:0] pull_en;
    logic [14:0] pull_up;
  } pwrseq_pads_t;

  // Software pin configuration, also the retained copy
  typedef struct packed {
    logic [14:0] out;
    logic [14:0] drive;
    logic [14:0] pull_en;
    logic [14:0] pull_up;
  } pwrseq_pincfg_t;

  // AHB-Lite slave side signals
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } pwrseq_ahb_rsp_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } pwrseq_ahb_req_t;

  // Divider state
  typedef struct packed {
    logic [7:0] osc_cnt;
    logic [7:0] lp_cnt;
    logic osc_tick;
    logic lp_tick;
  } pwrseq_div_t;

  // Whole state of the sequencer
  typedef struct packed {
    logic [17:0] in_s1;
    logic [17:0] in_s2;
    logic [17:0] in_s3;
    logic [17:0] in_lvl;
    pwrseq_state_t state;
    logic [15:0] stab_cnt;
    logic [15:0] hold_cnt;
    logic stable;
    logic [1:0] req;
    logic programmed;
    pwrseq_pincfg_t cfg;
    pwrseq_pincfg_t ret;
    logic [1:0] analog;
    logic dp_wr;
    logic [5:0] dp_addr;
    logic [31:0] hrdata;
    logic core_rst_n;
    pwrseq_pads_t pads;
  } pwrseq_regs_t;

endpackage : pwrseq_pkg

// *** hdl/pwrseq_lpclk_div.sv ***
// Divider making the 2MHz and 31.25kHz enable pulses
`timescale 1ns/1ps
`default_nettype none
`include "pwrseq_map.svh"

module pwrseq_lpclk_div #(
  parameter int OSC_DIV = `PWRSEQ_OSC_DIV,
  parameter int LP_DIV = `PWRSEQ_LP_DIV
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic run_in,
  output logic osc_tick_out,
  output logic lp_tick_out
);

  pwrseq_pkg::pwrseq_div_t r;
  pwrseq_pkg::pwrseq_div_t next_r;

  // Count oscillator periods, then 64 of them per low-power period
  always_comb
  begin
    next_r = r;
    next_r.osc_tick = 1'b0;
    next_r.lp_tick = 1'b0;
    if (!run_in)
    begin
      next_r.osc_cnt = 8'h00;
      next_r.lp_cnt = 8'h00;
    end
    else if (r.osc_cnt == 8'(OSC_DIV - 1))
    begin
      next_r.osc_cnt = 8'h00;
      next_r.osc_tick = 1'b1;
      if (r.lp_cnt == 8'(LP_DIV - 1))
      begin
        next_r.lp_cnt = 8'h00;
        next_r.lp_tick = 1'b1;
      end
      else
        next_r.lp_cnt = r.lp_cnt + 8'h01;
    end
    else
      next_r.osc_cnt = r.osc_cnt + 8'h01;
  end

  // Register the copy
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      r <= '0;
    else
      r <= next_r;
  end

  assign osc_tick_out = r.osc_tick;
  assign lp_tick_out = r.lp_tick;

endmodule : pwrseq_lpclk_div
`default_nettype wire

// *** hdl/pwrseq_top.sv ***
// Power state, reset hold and pin state sequencer with AHB-Lite registers
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwrseq_map.svh"

// Overview of operation
// - Enable high moves core-off to processor-only; enable low returns to core-off.
// - Past processor-only, software requests pick the state; supply-low or brownout forces reset hold, enable low forces core-off.
// - Wait at least 10 us after enable for the low-power clock.
// - Supply-low indication is high below threshold, low above it.
// - Brownout indication is high below threshold, low once restored.
// - Brownout resets the system just like supply-low at power-up.
// - Hold reset for 256 low-power periods of 64 oscillator cycles; the divider is not restarted at hold entry, so the first period can be short.
// - During reset hold all pins off, except wakeup pin pull-up.
// - Unprogrammed digital pins: inputs and pull-ups on; mixed pins fully off.
// - Mixed pins select analog or digital, analog default disables everything.
// - Deep sleep retains pin settings; wakeup pin stays live.
// - Analog mode on mixed pins overrides retention in deep sleep.
module pwrseq_top #(
  parameter int OSC_DIV = `PWRSEQ_OSC_DIV,
  parameter int LP_DIV = `PWRSEQ_LP_DIV,
  parameter int HOLD_PERIODS = `PWRSEQ_HOLD_PERIODS,
  parameter int TSTAB_CYC = `PWRSEQ_TSTAB_CYC
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CHIP_ENABLE_IN,
  input wire logic SUPPLY_LOW_DETECT_IN,
  input wire logic BATTERY_DROP_DETECT_IN,
  input wire logic [14:0] GPIO_IN,
  input wire pwrseq_pkg::pwrseq_ahb_req_t AHB_REQ_IN,
  output pwrseq_pkg::pwrseq_ahb_rsp_t AHB_RSP_OUT,
  output pwrseq_pkg::pwrseq_pads_t PADS_OUT,
  output logic CORE_RESET_N_OUT,
  output pwrseq_pkg::pwrseq_state_t POWER_STATE_OUT,
  output logic SUPPLY_LOW_OUT,
  output logic BATTERY_DROP_DETECT_OUT
);

  pwrseq_pkg::pwrseq_regs_t r;
  pwrseq_pkg::pwrseq_regs_t n;
  logic lp_tick;
  logic run_div;
  logic chip_en;
  logic supply_low;
  logic drop;
  logic powered;
  logic take;
  logic [5:0] rd_addr;
  logic [14:0] p_out;
  logic [14:0] p_oen;
  logic [14:0] p_ie;
  logic [14:0] p_pe;
  logic [14:0] p_pu;

  // Oscillator runs from enable onward; it settles during the wait state
  assign run_div = (r.state != pwrseq_pkg::PWRSEQ_OFF);

  pwrseq_lpclk_div #(
    .OSC_DIV(OSC_DIV),
    .LP_DIV(LP_DIV)
  ) u_div (
    .clk_in(CLK_IN),
    .resetn_in(RESETN_IN),
    .run_in(run_div),
    .osc_tick_out(),
    .lp_tick_out(lp_tick)
  );

  // Filtered pin levels
  assign chip_en = r.in_lvl[`PWRSEQ_IN_CHIP];
  assign supply_low = r.in_lvl[`PWRSEQ_IN_SLOW];
  assign drop = r.in_lvl[`PWRSEQ_IN_DROP];
  assign powered = (r.state == pwrseq_pkg::PWRSEQ_MCU_ONLY) ||
                   (r.state == pwrseq_pkg::PWRSEQ_RADIO_ACTIVE) ||
                   (r.state == pwrseq_pkg::PWRSEQ_DEEP_SLEEP);
  assign take = AHB_REQ_IN.hsel && AHB_REQ_IN.htrans[1] && AHB_REQ_IN.hready;
  assign rd_addr = AHB_REQ_IN.haddr[7:2];

  // Per-pin pad state for the present power state
  for (genvar i = 0; i < `PWRSEQ_N_PIN; i++)
  begin : g_pin
    localparam bit IS_MS = (i >= `PWRSEQ_FIRST_MS) &&
                           (i < `PWRSEQ_FIRST_MS + `PWRSEQ_N_MS);
    localparam bit IS_WAKE = (i == `PWRSEQ_WAKE_PIN);
    logic analog;
    logic live;
    logic o;
    logic d;
    logic pe;
    logic pu;
    logic lo;
    logic loen;
    logic lie;
    logic lpe;
    logic lpu;

    if (IS_MS)
    begin : g_ms
      assign analog = r.analog[i - `PWRSEQ_FIRST_MS];
    end
    else
    begin : g_dig
      assign analog = 1'b0;
    end

    // Wakeup pin never takes the retained copy
    assign live = IS_WAKE || (r.state != pwrseq_pkg::PWRSEQ_DEEP_SLEEP);
    assign o = live ? r.cfg.out[i] : r.ret.out[i];
    assign d = live ? r.cfg.drive[i] : r.ret.drive[i];
    assign pe = live ? r.cfg.pull_en[i] : r.ret.pull_en[i];
    assign pu = live ? r.cfg.pull_up[i] : r.ret.pull_up[i];

    always_comb
    begin
      lo = 1'b0;
      loen = 1'b1;
      lie = 1'b0;
      lpe = 1'b0;
      lpu = 1'b0;
      case (r.state)
        pwrseq_pkg::PWRSEQ_OFF:
        begin
          lpe = 1'b0;
        end
        pwrseq_pkg::PWRSEQ_OSC_WAIT, pwrseq_pkg::PWRSEQ_HOLD:
        begin
          lpe = IS_WAKE;
          lpu = IS_WAKE;
        end
        pwrseq_pkg::PWRSEQ_MCU_ONLY, pwrseq_pkg::PWRSEQ_RADIO_ACTIVE,
        pwrseq_pkg::PWRSEQ_DEEP_SLEEP:
        begin
          if (!r.programmed)
          begin
            lie = !IS_MS;
            lpe = !IS_MS;
            lpu = !IS_MS;
          end
          else if (!analog)
          begin
            lo = o;
            loen = !d;
            lie = !d;
            lpe = pe;
            lpu = pu;
          end
        end
        default:
        begin
          loen = 1'b1;
        end
      endcase
    end

    assign p_out[i] = lo;
    assign p_oen[i] = loen;
    assign p_ie[i] = lie;
    assign p_pe[i] = lpe;
    assign p_pu[i] = lpu;
  end

  // Next state: synchronisers, power states, registers, bus
  always_comb
  begin
    n = r;

    // Three flops; a level counts once second and third agree
    n.in_s1 = {BATTERY_DROP_DETECT_IN, SUPPLY_LOW_DETECT_IN, CHIP_ENABLE_IN,
               GPIO_IN};
    n.in_s2 = r.in_s1;
    n.in_s3 = r.in_s2;
    n.in_lvl = (r.in_s2 & r.in_s3) | (r.in_lvl & (r.in_s2 ^ r.in_s3));

    // Power state sequencing
    case (r.state)
      pwrseq_pkg::PWRSEQ_OFF:
      begin
        n.stab_cnt = 16'h0000;
        n.stable = 1'b0;
        if (chip_en)
          n.state = pwrseq_pkg::PWRSEQ_OSC_WAIT;
      end
      pwrseq_pkg::PWRSEQ_OSC_WAIT:
      begin
        // Nothing leans on the slow clock before it has settled
        n.stab_cnt = r.stab_cnt + 16'h0001;
        if (r.stab_cnt == 16'(TSTAB_CYC - 1))
        begin
          n.stable = 1'b1;
          n.hold_cnt = 16'h0000;
          n.state = pwrseq_pkg::PWRSEQ_HOLD;
        end
      end
      pwrseq_pkg::PWRSEQ_HOLD:
      begin
        if (supply_low || drop)
          n.hold_cnt = 16'h0000;
        else if (lp_tick)
        begin
          if (r.hold_cnt == 16'(HOLD_PERIODS - 1))
            n.state = pwrseq_pkg::PWRSEQ_MCU_ONLY;
          else
            n.hold_cnt = r.hold_cnt + 16'h0001;
        end
      end
      pwrseq_pkg::PWRSEQ_MCU_ONLY, pwrseq_pkg::PWRSEQ_RADIO_ACTIVE,
      pwrseq_pkg::PWRSEQ_DEEP_SLEEP:
      begin
        // Only the software request moves between running states
        case (r.req)
          `PWRSEQ_REQ_MCU: n.state = pwrseq_pkg::PWRSEQ_MCU_ONLY;
          `PWRSEQ_REQ_RADIO: n.state = pwrseq_pkg::PWRSEQ_RADIO_ACTIVE;
          `PWRSEQ_REQ_SLEEP: n.state = pwrseq_pkg::PWRSEQ_DEEP_SLEEP;
          default: n.state = r.state;
        endcase
        if (supply_low || drop)
        begin
          n.hold_cnt = 16'h0000;
          n.state = pwrseq_pkg::PWRSEQ_HOLD;
        end
      end
      default:
      begin
        n.state = pwrseq_pkg::PWRSEQ_OFF;
      end
    endcase
    if (!chip_en)
      n.state = pwrseq_pkg::PWRSEQ_OFF;

    // Capture pin settings on the way into deep sleep
    if ((r.state != pwrseq_pkg::PWRSEQ_DEEP_SLEEP) &&
        (n.state == pwrseq_pkg::PWRSEQ_DEEP_SLEEP))
      n.ret = r.cfg;

    // Bus data phase write; registers only live while the core runs
    if (r.dp_wr && powered)
    begin
      case ({r.dp_addr, 2'b00})
        `PWRSEQ_CTRL_OFS:
        begin
          n.req = AHB_REQ_IN.hwdata[`PWRSEQ_CTRL_REQ_LSB +: 2];
          n.programmed = AHB_REQ_IN.hwdata[`PWRSEQ_CTRL_PROG_BIT];
        end
        `PWRSEQ_PIN_OUT_OFS: n.cfg.out = AHB_REQ_IN.hwdata[14:0];
        `PWRSEQ_PIN_DRIVE_OFS: n.cfg.drive = AHB_REQ_IN.hwdata[14:0];
        `PWRSEQ_PIN_PULL_EN_OFS: n.cfg.pull_en = AHB_REQ_IN.hwdata[14:0];
        `PWRSEQ_PIN_PULL_UP_OFS: n.cfg.pull_up = AHB_REQ_IN.hwdata[14:0];
        `PWRSEQ_ANALOG_OFS: n.analog = AHB_REQ_IN.hwdata[1:0];
        default: n.req = n.req;
      endcase
    end

    // Reset hold wipes software state back to defaults
    if (!powered)
    begin
      n.req = `PWRSEQ_REQ_MCU;
      n.programmed = 1'b0;
      n.cfg = '0;
      n.ret = '0;
      n.analog = `PWRSEQ_ANALOG_RST;
    end

    // Address phase; read data built from next values so writes forward
    n.dp_wr = take && AHB_REQ_IN.hwrite;
    n.dp_addr = rd_addr;
    n.hrdata = 32'h0000_0000;
    if (take && !AHB_REQ_IN.hwrite)
    begin
      case ({rd_addr, 2'b00})
        `PWRSEQ_CTRL_OFS: n.hrdata = {29'h0, n.programmed, n.req};
        `PWRSEQ_STATUS_OFS:
          n.hrdata = {25'h0, r.programmed, r.stable, drop, supply_low,
                      r.state};
        `PWRSEQ_PIN_OUT_OFS: n.hrdata = {17'h0, n.cfg.out};
        `PWRSEQ_PIN_DRIVE_OFS: n.hrdata = {17'h0, n.cfg.drive};
        `PWRSEQ_PIN_PULL_EN_OFS: n.hrdata = {17'h0, n.cfg.pull_en};
        `PWRSEQ_PIN_PULL_UP_OFS: n.hrdata = {17'h0, n.cfg.pull_up};
        `PWRSEQ_ANALOG_OFS: n.hrdata = {30'h0, n.analog};
        `PWRSEQ_PIN_LEVEL_OFS: n.hrdata = {17'h0, r.in_lvl[14:0]};
        default: n.hrdata = 32'h0000_0000;
      endcase
    end

    // Pad and reset outputs from flops
    n.pads = '{out: p_out, oe_n: p_oen, in_en: p_ie, pull_en: p_pe,
               pull_up: p_pu};
    n.core_rst_n = (n.state == pwrseq_pkg::PWRSEQ_MCU_ONLY) ||
                   (n.state == pwrseq_pkg::PWRSEQ_RADIO_ACTIVE) ||
                   (n.state == pwrseq_pkg::PWRSEQ_DEEP_SLEEP);
  end

  // Register the copy; pads come up fully off
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      r <= '0;
      r.state <= pwrseq_pkg::PWRSEQ_OFF;
      r.analog <= `PWRSEQ_ANALOG_RST;
      r.pads.oe_n <= 15'h7fff;
    end
    else
      r <= n;
  end

  // Zero-wait slave, always OKAY
  assign AHB_RSP_OUT.hrdata = r.hrdata;
  assign AHB_RSP_OUT.hreadyout = 1'b1;
  assign AHB_RSP_OUT.hresp = 1'b0;
  assign PADS_OUT = r.pads;
  assign CORE_RESET_N_OUT = r.core_rst_n;
  assign POWER_STATE_OUT = r.state;
  assign SUPPLY_LOW_OUT = supply_low;
  assign BATTERY_DROP_DETECT_OUT = drop;

endmodule : pwrseq_top
`default_nettype wire

// *** sim/pwrseq_top_properties.sv ***
// Concurrent checks on the sequencer top ports
`timescale 1ns/1ps
`default_nettype none
module pwrseq_top_properties #(
  parameter int OSC_DIV = 10,
  parameter int LP_DIV = 64,
  parameter int HOLD_PERIODS = 256,
  parameter int TSTAB_CYC = 200
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CHIP_ENABLE_IN,
  input wire logic SUPPLY_LOW_DETECT_IN,
  input wire logic BATTERY_DROP_DETECT_IN,
  input wire pwrseq_pkg::pwrseq_pads_t PADS_OUT,
  input wire logic CORE_RESET_N_OUT,
  input wire pwrseq_pkg::pwrseq_state_t POWER_STATE_OUT,
  input wire logic SUPPLY_LOW_OUT,
  input wire logic BATTERY_DROP_DETECT_OUT
);
  // Slack for the tick phase at hold entry
  localparam int MIN_HOLD = (HOLD_PERIODS - 1) * OSC_DIV * LP_DIV - 2;
  logic [19:0] quiet;
  logic [15:0] waited;
  logic held;
  logic off;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  // State classes
  assign off = POWER_STATE_OUT == pwrseq_pkg::PWRSEQ_OFF;
  assign held = POWER_STATE_OUT inside
    {pwrseq_pkg::PWRSEQ_OSC_WAIT, pwrseq_pkg::PWRSEQ_HOLD};
  // Raw detectors clear early, so this only bounds the count from above
  always_ff @(posedge CLK_IN)
  begin
    if (!RESETN_IN || POWER_STATE_OUT != pwrseq_pkg::PWRSEQ_HOLD
        || SUPPLY_LOW_DETECT_IN || BATTERY_DROP_DETECT_IN)
      quiet <= 20'h0;
    else
      quiet <= quiet + 20'h1;
    if (!RESETN_IN || POWER_STATE_OUT != pwrseq_pkg::PWRSEQ_OSC_WAIT)
      waited <= 16'h0;
    else
      waited <= waited + 16'h1;
  end
  off_pads_a: assert property (
    $past(off) && off |-> PADS_OUT.oe_n == 15'h7fff
      && PADS_OUT.in_en == 15'h0 && PADS_OUT.pull_en == 15'h0)
    else $error("pads active while core is off");
  hold_pads_a: assert property (
    $past(held) && held |-> PADS_OUT.oe_n == 15'h7fff
      && PADS_OUT.in_en == 15'h0 && PADS_OUT.pull_en == 15'h4000
      && PADS_OUT.pull_up[14])
    else $error("pads wrong during reset hold");
  core_reset_a: assert property (
    CORE_RESET_N_OUT == !(off || held))
    else $error("core reset disagrees with state");
  wake_entry_a: assert property (
    $past(off) && !off |->
      POWER_STATE_OUT == pwrseq_pkg::PWRSEQ_OSC_WAIT
      && $past(CHIP_ENABLE_IN, 3))
    else $error("left off state without enable");
  enable_off_a: assert property (
    !CHIP_ENABLE_IN [*8] |-> off)
    else $error("enable low but not off");
  settle_time_a: assert property (
    $past(POWER_STATE_OUT) == pwrseq_pkg::PWRSEQ_OSC_WAIT
      && POWER_STATE_OUT == pwrseq_pkg::PWRSEQ_HOLD
      |-> $past(waited) >= TSTAB_CYC - 1)
    else $error("clock settling wait too short");
  hold_count_a: assert property (
    $past(POWER_STATE_OUT) == pwrseq_pkg::PWRSEQ_HOLD && !held
      && !off |-> $past(quiet) >= MIN_HOLD)
    else $error("reset hold released early");
  detect_reset_a: assert property (
    (SUPPLY_LOW_DETECT_IN || BATTERY_DROP_DETECT_IN) [*8]
      |-> !CORE_RESET_N_OUT)
    else $error("detector did not reset core");
  supply_follow_a: assert property (
    $stable(SUPPLY_LOW_DETECT_IN) [*7]
      |-> SUPPLY_LOW_OUT == SUPPLY_LOW_DETECT_IN)
    else $error("supply low level not followed");
  drop_follow_a: assert property (
    $stable(BATTERY_DROP_DETECT_IN) [*7]
      |-> BATTERY_DROP_DETECT_OUT == BATTERY_DROP_DETECT_IN)
    else $error("brownout level not followed");
endmodule : pwrseq_top_properties
bind pwrseq_top pwrseq_top_properties #(.OSC_DIV(OSC_DIV),
  .LP_DIV(LP_DIV), .HOLD_PERIODS(HOLD_PERIODS), .TSTAB_CYC(TSTAB_CYC))
  props_i (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
  .CHIP_ENABLE_IN(CHIP_ENABLE_IN),
  .SUPPLY_LOW_DETECT_IN(SUPPLY_LOW_DETECT_IN),
  .BATTERY_DROP_DETECT_IN(BATTERY_DROP_DETECT_IN), .PADS_OUT(PADS_OUT),
  .CORE_RESET_N_OUT(CORE_RESET_N_OUT), .POWER_STATE_OUT(POWER_STATE_OUT),
  .SUPPLY_LOW_OUT(SUPPLY_LOW_OUT),
  .BATTERY_DROP_DETECT_OUT(BATTERY_DROP_DETECT_OUT));
`default_nettype wire

// *** sim/pwrseq_host_model.sv ***
// Board power model: IO rail and chip enable ordering
`timescale 1ns/1ps
`default_nettype none
module pwrseq_host_model (
  input wire logic clk_in,
  input wire logic want_power_in,
  output logic chip_enable_out,
  output logic io_supply_rail_out
);
  // Enable starts at a firm low, never floating
  initial
  begin
    chip_enable_out = 1'b0;
    io_supply_rail_out = 1'b0;
  end
  // Rail leads enable on the way up and trails it on the way down
  always @(posedge clk_in)
  begin
    if (want_power_in)
    begin
      io_supply_rail_out <= 1'b1;
      chip_enable_out <= io_supply_rail_out;
    end
    else
    begin
      chip_enable_out <= 1'b0;
      io_supply_rail_out <= chip_enable_out;
    end
  end
endmodule : pwrseq_host_model
`default_nettype wire

// *** sim/pwrseq_top_test.sv ***
// Self-checking bench of the power sequencer
`timescale 1ns/1ps
`default_nettype none
module pwrseq_top_test;
  localparam int TICK = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic want = 1'b0;
  logic slow = 1'b0;
  logic drop = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic en, rail, core_n, slow_o, drop_o;
  logic [31:0] reqs [3] = '{32'h1, 32'h2, 32'h0};
  logic [31:0] stats [3] = '{32'h64, 32'h65, 32'h63};
  int fails = 0;
  int samples_checked = 0;
  int n;
  pwrseq_pkg::pwrseq_ahb_req_t req;
  pwrseq_pkg::pwrseq_ahb_rsp_t rsp;
  pwrseq_pkg::pwrseq_pads_t pads;
  pwrseq_pkg::pwrseq_state_t st;
  // Slave ready is the bus ready
  assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};
  initial
  begin
    forever #25 clk = ~clk;
  end
  pwrseq_host_model host (.clk_in(clk), .want_power_in(want),
    .chip_enable_out(en), .io_supply_rail_out(rail));
  // Shortened counts keep the hold near thirty cycles
  pwrseq_top #(.OSC_DIV(2), .LP_DIV(4), .HOLD_PERIODS(4), .TSTAB_CYC(4))
    dut (.CLK_IN(clk), .RESETN_IN(rstn), .CHIP_ENABLE_IN(en),
    .SUPPLY_LOW_DETECT_IN(slow), .BATTERY_DROP_DETECT_IN(drop),
    .GPIO_IN(15'h2a5c), .AHB_REQ_IN(req), .AHB_RSP_OUT(rsp),
    .PADS_OUT(pads), .CORE_RESET_N_OUT(core_n), .POWER_STATE_OUT(st),
    .SUPPLY_LOW_OUT(slow_o), .BATTERY_DROP_DETECT_OUT(drop_o));
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic give_up();
    fails++;
    test_done();
  endtask : give_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic ready_edge();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (rsp.hreadyout !== 1'b1 && k < 20);
    if (k >= 20)
      give_up();
  endtask : ready_edge
  // One single word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ready_edge();
    rd = rsp.hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic wait_state(input pwrseq_pkg::pwrseq_state_t s);
    n = 0;
    while (st !== s && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (st !== s)
      give_up();
  endtask : wait_state
  // Pads lag their cause by one registered edge
  task automatic pads_chk(input logic [14:0] oe_n, ie, pe);
    repeat (2) @(posedge clk);
    chk({17'h0, pads.oe_n}, {17'h0, oe_n});
    chk({17'h0, pads.in_en}, {17'h0, ie});
    chk({17'h0, pads.pull_en}, {17'h0, pe});
  endtask : pads_chk
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    pads_chk(15'h7fff, 15'h0, 15'h0);
    want <= 1'b1;
    wait_state(pwrseq_pkg::PWRSEQ_MCU_ONLY);
    chk(core_n, 32'h1);
    pads_chk(15'h7fff, 15'h4fff, 15'h4fff);
    chk({17'h0, pads.pull_up}, 32'h4fff);
    rdchk(8'h04, 32'h23);
    rdchk(8'h1c, 32'h2a5c);
    bus(1'b1, 8'h0c, 32'h100f);
    bus(1'b1, 8'h10, 32'h1030);
    bus(1'b1, 8'h08, 32'h0005);
    bus(1'b1, 8'h18, 32'h0002);
    pads_chk(15'h7fff, 15'h4fff, 15'h4fff);
    bus(1'b1, 8'h00, 32'h4);
    pads_chk(15'h6ff0, 15'h4ff0, 15'h1030);
    chk({17'h0, pads.out}, 32'h5);
    chk({17'h0, pads.pull_up}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, 8'h00, 32'h4 | reqs[i]);
      repeat (2) @(posedge clk);
      rdchk(8'h04, stats[i]);
    end
    bus(1'b1, 8'h00, 32'h6);
    bus(1'b1, 8'h0c, 32'h4000);
    pads_chk(15'h2ff0, 15'h0ff0, 15'h1030);
    bus(1'b1, 8'h18, 32'h3);
    pads_chk(15'h3ff0, 15'h0ff0, 15'h0030);
    bus(1'b1, 8'h00, 32'h4);
    drop <= 1'b1;
    repeat (10) @(posedge clk);
    chk(drop_o, 32'h1);
    chk(st, pwrseq_pkg::PWRSEQ_HOLD);
    rdchk(8'h0c, 32'h0);
    drop <= 1'b0;
    repeat (12) @(posedge clk);
    slow <= 1'b1;
    repeat (10) @(posedge clk);
    chk(slow_o, 32'h1);
    chk(st, pwrseq_pkg::PWRSEQ_HOLD);
    slow <= 1'b0;
    wait_state(pwrseq_pkg::PWRSEQ_MCU_ONLY);
    chk(n >= 3 * TICK && n <= 4 * TICK + 12, 32'h1);
    chk(slow_o, 32'h0);
    want <= 1'b0;
    wait_state(pwrseq_pkg::PWRSEQ_OFF);
    chk(n <= 10, 32'h1);
    pads_chk(15'h7fff, 15'h0, 15'h0);
    test_done();
  end
endmodule : pwrseq_top_test
`default_nettype wire
